// ===== hw/dpmc_pkg.sv
// Shared constants and types for the dual-function control pin decoder
package dpmc_pkg;

	// Sample word width of one converter channel
	localparam int unsigned DPMC_DATA_W = 14;

	// Register bus geometry
	localparam int unsigned DPMC_ADDR_W = 8;
	localparam int unsigned DPMC_BUS_W  = 32;

	// Register byte offsets
	localparam logic [7:0] DPMC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] DPMC_OFF_STATUS = 8'h04;
	localparam logic [7:0] DPMC_OFF_SAMPLE = 8'h08;

	// Control register fields; format, power-down and phase apply outside pin mode, the output enables and reference drive in every mode
	localparam int unsigned DPMC_CTRL_TWOS_BIT   = 0;
	localparam int unsigned DPMC_CTRL_PDOWN_BIT  = 1;
	localparam int unsigned DPMC_CTRL_IRSET_BIT  = 2;
	localparam int unsigned DPMC_CTRL_QRSET_BIT  = 3;
	localparam int unsigned DPMC_CTRL_INTREF_BIT = 4;
	localparam int unsigned DPMC_CTRL_PHASE_BIT  = 5;
	localparam int unsigned DPMC_CTRL_W          = 6;
	localparam logic [5:0]  DPMC_CTRL_RESET      = 6'h00;

	// Status register fields
	localparam int unsigned DPMC_STAT_PINMODE_BIT = 0;
	localparam int unsigned DPMC_STAT_TWOS_BIT    = 1;
	localparam int unsigned DPMC_STAT_PDOWN_BIT   = 2;
	localparam int unsigned DPMC_STAT_PHASE_BIT   = 3;
	localparam int unsigned DPMC_STAT_VALID_BIT   = 4;
	localparam int unsigned DPMC_STAT_W           = 5;

	// Sample register layout: in-phase low half, quadrature high half
	localparam int unsigned DPMC_SAMPLE_Q_LSB = 16;

	// Bus response codes
	localparam logic [1:0] DPMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] DPMC_RESP_SLVERR = 2'h2;

	// Strap capture sequence
	typedef enum logic [1:0] {
		DPMC_STRAP_WAIT,
		DPMC_STRAP_SERIAL,
		DPMC_STRAP_PIN
	} dpmc_strap_t;

endpackage

// ===== hw/dpmc_rise_det.sv
// Rising-edge detector for a synchronous control pin
`timescale 1ns/1ps
module dpmc_rise_det
	import dpmc_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	// Level and its edge
	input  wire logic level_in,
	output logic      rise_out
);

	logic prev_r;

	// Previous level, cleared so a pin already high at reset counts as an edge
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			prev_r <= 1'b0;
		else
			prev_r <= level_in;
	end

	// One-cycle pulse on a 0-to-1 change
	assign rise_out = level_in & ~prev_r;

endmodule // dpmc_rise_det

// ===== hw/dpmc_code_conv.sv
// Input format conversion to the converter core's straight binary code
`timescale 1ns/1ps
module dpmc_code_conv
	import dpmc_pkg::*;
(
	// Format select
	input  wire logic                   twos_in,
	// Sample word in
	input  wire logic [DPMC_DATA_W-1:0] word_in,
	// Codes for the true and complementary outputs
	output logic [DPMC_DATA_W-1:0]      true_out,
	output logic [DPMC_DATA_W-1:0]      comp_out
);

	logic msb_flip;

	// Twos complement becomes offset binary by inverting the top bit
	assign msb_flip = twos_in;
	assign true_out = {word_in[DPMC_DATA_W-1] ^ msb_flip,
	                   word_in[DPMC_DATA_W-2:0]};
	// Complement output peaks at code zero, true output at all ones
	assign comp_out = ~true_out;

endmodule // dpmc_code_conv

// ===== hw/dpmc_top.sv
// Dual-function control pin decoder with register access over AXI4-Lite
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module dpmc_top
	import dpmc_pkg::*;
(
	// Clock and reset
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_in,
	// Mode strap, also the serial register reset
	input  wire logic                   strap_mode_select_in,
	// Clock-mode pin, also the serial clock
	input  wire logic                   retime_phase_pin_in,
	// Format pin, also the serial data line
	input  wire logic                   format_pin_in,
	output logic                        format_pin_out,
	output logic                        format_pin_oe_out,
	// Power-down pin, also the serial chip select
	input  wire logic                   powerdown_pin_in,
	// Serial engine side
	output logic                        serial_clk_out,
	output logic                        serial_cs_n_out,
	output logic                        serial_data_out,
	input  wire logic                   serial_data_drive_in,
	input  wire logic                   serial_data_oe_in,
	output logic                        serial_regs_reset_out,
	// Parallel sample input and its qualifying clock
	input  wire logic                   data_qualify_clock_in,
	input  wire logic [DPMC_DATA_W-1:0] sample_data_in,
	// Converter core codes
	output logic [DPMC_DATA_W-1:0]      inphase_true_code_out,
	output logic [DPMC_DATA_W-1:0]      inphase_complement_code_out,
	output logic [DPMC_DATA_W-1:0]      quad_true_code_out,
	output logic [DPMC_DATA_W-1:0]      quad_complement_code_out,
	// Core controls
	output logic                        core_powerdown_out,
	output logic                        retime_phase_out,
	output logic                        retime_align_out,
	output logic                        inphase_aux_output_en_out,
	output logic                        quad_aux_output_en_out,
	output logic                        reference_pin_drive_out,
	// AXI4-Lite write address
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [DPMC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	input  wire logic [DPMC_BUS_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	// AXI4-Lite write response
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	output logic [1:0]                  s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	input  wire logic [DPMC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	// AXI4-Lite read data
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [DPMC_BUS_W-1:0]       s_axi_rdata,
	output logic [1:0]                  s_axi_rresp
);

	// Address decode shared by read and write paths
	function automatic logic [1:0] dpmc_decode(input logic [DPMC_ADDR_W-1:0] addr);
		logic [1:0] sel;
		sel = 2'h3;
		if (addr == DPMC_OFF_CTRL)
			sel = 2'h0;
		else if (addr == DPMC_OFF_STATUS)
			sel = 2'h1;
		else if (addr == DPMC_OFF_SAMPLE)
			sel = 2'h2;
		return sel;
	endfunction

	dpmc_strap_t              strap_state_r;
	dpmc_strap_t              strap_state_nxt;
	logic [DPMC_CTRL_W-1:0]   ctrl_r;
	logic [DPMC_CTRL_W-1:0]   ctrl_nxt;
	logic                     pin_mode;
	logic                     serial_mode;
	logic                     serial_reset;
	logic                     eff_twos;
	logic                     eff_pdown;
	logic                     phase_rise;
	logic                     dclk_rise;
	logic                     dclk_fall;
	logic                     dclk_prev_r;
	logic                     retime_phase_r;
	logic                     retime_align_r;
	logic                     sample_valid_r;
	logic [DPMC_DATA_W-1:0]   inphase_word_r;
	logic [DPMC_DATA_W-1:0]   quad_word_r;
	logic [DPMC_DATA_W-1:0]   i_true;
	logic [DPMC_DATA_W-1:0]   i_comp;
	logic [DPMC_DATA_W-1:0]   q_true;
	logic [DPMC_DATA_W-1:0]   q_comp;
	logic                     aw_held_r;
	logic [DPMC_ADDR_W-1:0]   aw_addr_r;
	logic                     w_held_r;
	logic [DPMC_BUS_W-1:0]    w_data_r;
	logic [3:0]               w_strb_r;
	logic                     wr_fire;
	logic [1:0]               wr_sel;
	logic                     wr_ctrl;
	logic [1:0]               rd_sel;
	logic [DPMC_BUS_W-1:0]    rd_word;
	logic [DPMC_STAT_W-1:0]   status_word;

	// Strap is caught once after reset release, then the mode is fixed
	always_comb
	begin
		strap_state_nxt = strap_state_r;
		case (strap_state_r)
			DPMC_STRAP_WAIT:
				strap_state_nxt = strap_mode_select_in ? DPMC_STRAP_PIN
				                                       : DPMC_STRAP_SERIAL;
			DPMC_STRAP_SERIAL:
				strap_state_nxt = DPMC_STRAP_SERIAL;
			DPMC_STRAP_PIN:
				strap_state_nxt = DPMC_STRAP_PIN;
			default:
				strap_state_nxt = DPMC_STRAP_WAIT;
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			strap_state_r <= DPMC_STRAP_WAIT;
		else
			strap_state_r <= strap_state_nxt;
	end

	// Mode decode; the serial pins idle until the strap is known
	assign pin_mode     = (strap_state_r == DPMC_STRAP_PIN);
	assign serial_mode  = (strap_state_r == DPMC_STRAP_SERIAL);
	// Strap going high once serial mode is fixed is the register reset pulse
	assign serial_reset = serial_mode & strap_mode_select_in;

	// Effective format and power-down from pins or from software
	assign eff_twos  = pin_mode ? format_pin_in
	                            : ctrl_r[DPMC_CTRL_TWOS_BIT];
	assign eff_pdown = pin_mode ? powerdown_pin_in
	                            : ctrl_r[DPMC_CTRL_PDOWN_BIT];

	// Serial pin routing; pin mode never drives the shared data line
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			serial_clk_out    <= 1'b0;
			serial_cs_n_out   <= 1'b1;
			serial_data_out   <= 1'b0;
			format_pin_out    <= 1'b0;
			format_pin_oe_out <= 1'b0;
		end
		else
		begin
			serial_clk_out    <= serial_mode & retime_phase_pin_in;
			serial_cs_n_out   <= ~serial_mode | powerdown_pin_in;
			serial_data_out   <= serial_mode & format_pin_in;
			format_pin_out    <= serial_data_drive_in;
			format_pin_oe_out <= serial_mode & serial_data_oe_in
			                     & ~powerdown_pin_in;
		end
	end

	// Reset pulse handed to the serial engine's own registers
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			serial_regs_reset_out <= 1'b1;
		else
			serial_regs_reset_out <= serial_reset;
	end

	// Edge of the clock-mode pin triggers the retimer; held low means none
	dpmc_rise_det u_phase_rise (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.level_in    (retime_phase_pin_in),
		.rise_out    (phase_rise)
	);

	// Phase stays at the aligned setting until the next reset
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			retime_phase_r <= 1'b0;
			retime_align_r <= 1'b0;
		end
		else
		begin
			retime_align_r <= pin_mode & phase_rise;
			if (pin_mode & phase_rise)
				retime_phase_r <= 1'b1;
		end
	end

	assign retime_phase_out = pin_mode ? retime_phase_r
	                                   : ctrl_r[DPMC_CTRL_PHASE_BIT];
	assign retime_align_out = retime_align_r;

	// Data clock edges; in-phase on the rising edge, quadrature on the falling
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			dclk_prev_r <= 1'b0;
		else
			dclk_prev_r <= data_qualify_clock_in;
	end

	assign dclk_rise = data_qualify_clock_in & ~dclk_prev_r;
	assign dclk_fall = ~data_qualify_clock_in & dclk_prev_r;

	// Sample capture, frozen while powered down to save toggling
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			inphase_word_r <= '0;
			quad_word_r    <= '0;
			sample_valid_r <= 1'b0;
		end
		else if (!eff_pdown)
		begin
			if (dclk_rise)
				inphase_word_r <= sample_data_in;
			if (dclk_fall)
			begin
				quad_word_r    <= sample_data_in;
				sample_valid_r <= 1'b1;
			end
		end
	end

	// Format conversion per channel
	dpmc_code_conv u_conv_i (
		.twos_in  (eff_twos),
		.word_in  (inphase_word_r),
		.true_out (i_true),
		.comp_out (i_comp)
	);

	dpmc_code_conv u_conv_q (
		.twos_in  (eff_twos),
		.word_in  (quad_word_r),
		.true_out (q_true),
		.comp_out (q_comp)
	);

	// Core codes and controls registered toward the converter core
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			inphase_true_code_out       <= '0;
			inphase_complement_code_out <= '0;
			quad_true_code_out          <= '0;
			quad_complement_code_out    <= '0;
			core_powerdown_out          <= 1'b0;
			inphase_aux_output_en_out   <= 1'b0;
			quad_aux_output_en_out      <= 1'b0;
			reference_pin_drive_out     <= 1'b0;
		end
		else
		begin
			inphase_true_code_out       <= i_true;
			inphase_complement_code_out <= i_comp;
			quad_true_code_out          <= q_true;
			quad_complement_code_out    <= q_comp;
			core_powerdown_out          <= eff_pdown;
			inphase_aux_output_en_out   <= ctrl_r[DPMC_CTRL_IRSET_BIT];
			quad_aux_output_en_out      <= ctrl_r[DPMC_CTRL_QRSET_BIT];
			reference_pin_drive_out     <= ctrl_r[DPMC_CTRL_INTREF_BIT];
		end
	end

	// Write side: address and data are held separately, either may come first
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
	assign wr_fire       = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_sel        = dpmc_decode(aw_addr_r);
	assign wr_ctrl       = wr_fire & (wr_sel == 2'h0) & w_strb_r[0];

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_held_r  <= 1'b0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held_r <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held_r <= 1'b0;
		end
	end

	// Write response; only the control word is writable
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= DPMC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == 2'h0) ? DPMC_RESP_OKAY : DPMC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Control register; the strap pulse wins over a software write
	assign ctrl_nxt = serial_reset ? DPMC_CTRL_RESET
	                : wr_ctrl      ? w_data_r[DPMC_CTRL_W-1:0]
	                               : ctrl_r;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			ctrl_r <= DPMC_CTRL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	// Status word shows the decoded mode and live controls
	assign status_word = {sample_valid_r, retime_phase_out, eff_pdown,
	                      eff_twos, pin_mode};

	// Read decode
	assign rd_sel  = dpmc_decode(s_axi_araddr);
	assign rd_word = (rd_sel == 2'h0) ? {{(DPMC_BUS_W-DPMC_CTRL_W){1'b0}}, ctrl_r}
	               : (rd_sel == 2'h1) ? {{(DPMC_BUS_W-DPMC_STAT_W){1'b0}}, status_word}
	               : (rd_sel == 2'h2) ? {2'h0, quad_word_r, 2'h0, inphase_word_r}
	                                  : '0;
	assign s_axi_arready = ~s_axi_rvalid;

	// Read data one cycle after the address is taken
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= DPMC_RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_sel == 2'h3) ? DPMC_RESP_SLVERR : DPMC_RESP_OKAY;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // dpmc_top

// ===== sim/dpmc_assertions.sv
// Port-level checks for the dual-function control pin decoder
`timescale 1ns/1ps
module dpmc_chk
	import dpmc_pkg::*;
(
	// Clock and reset
	input wire logic                   core_clk_in,
	input wire logic                   rst_in,
	// Shared pins and serial engine inputs
	input wire logic                   strap_mode_select_in,
	input wire logic                   retime_phase_pin_in,
	input wire logic                   format_pin_in,
	input wire logic                   powerdown_pin_in,
	input wire logic                   serial_data_drive_in,
	input wire logic                   serial_data_oe_in,
	// Decoded outputs
	input wire logic                   format_pin_out,
	input wire logic                   format_pin_oe_out,
	input wire logic                   serial_clk_out,
	input wire logic                   serial_cs_n_out,
	input wire logic                   serial_data_out,
	input wire logic                   serial_regs_reset_out,
	input wire logic                   core_powerdown_out,
	input wire logic                   retime_phase_out,
	input wire logic                   retime_align_out,
	input wire logic [DPMC_DATA_W-1:0] inphase_true_code_out,
	input wire logic [DPMC_DATA_W-1:0] inphase_complement_code_out,
	input wire logic [DPMC_DATA_W-1:0] quad_true_code_out,
	input wire logic [DPMC_DATA_W-1:0] quad_complement_code_out,
	// Read channel handshake
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	// Strap latched once; outputs are trusted a cycle after the latch settles
	logic known_r;
	logic ok_r;
	logic pin_r;
	always_ff @(posedge core_clk_in)
	begin
		known_r <= !rst_in;
		ok_r    <= known_r && !rst_in;
		pin_r   <= (rst_in || known_r) ? (pin_r && !rst_in) : strap_mode_select_in;
	end
	wire logic ser  = ok_r & ~pin_r;
	wire logic pinm = ok_r & pin_r;

	// Retimer trigger and its one-cycle answer
	sequence s_rise;
		!retime_phase_pin_in ##1 retime_phase_pin_in;
	endsequence
	sequence s_pulse;
		retime_align_out ##1 !retime_align_out;
	endsequence

	a_pin_idle: assert property (pinm |-> !serial_clk_out && serial_cs_n_out && !format_pin_oe_out)
		else $error("serial activity in pin mode");
	a_regs_reset: assert property (ser && $past(strap_mode_select_in) |-> serial_regs_reset_out)
		else $error("strap pulse did not reset serial registers");
	a_sclk_follow: assert property (ser |-> serial_clk_out == $past(retime_phase_pin_in))
		else $error("serial clock does not follow clock-mode pin");
	a_sdata_follow: assert property (ser |-> serial_data_out == $past(format_pin_in))
		else $error("serial data does not follow format pin");
	a_cs_follow: assert property (ser |-> serial_cs_n_out == $past(powerdown_pin_in))
		else $error("chip select does not follow power-down pin");
	a_drive_gate: assert property (format_pin_oe_out |-> ser && $past(serial_data_oe_in)
		&& format_pin_out == $past(serial_data_drive_in))
		else $error("data line driven outside a serial transfer");
	a_align_rise: assert property (pinm ##0 s_rise |-> ##[1:3] s_pulse)
		else $error("no single align pulse after clock-mode rise");
	a_phase_set: assert property (pinm && retime_align_out |-> retime_phase_out)
		else $error("align pulse without retime phase");
	a_phase_hold: assert property (pinm && retime_phase_out |=> retime_phase_out)
		else $error("retime phase dropped");
	a_pd_follow: assert property (pinm |-> core_powerdown_out == $past(powerdown_pin_in))
		else $error("power-down does not follow its pin");
	a_comp_inv: assert property ($changed(inphase_true_code_out) || $changed(quad_true_code_out)
		|-> inphase_complement_code_out == ~inphase_true_code_out
		&& quad_complement_code_out == ~quad_true_code_out)
		else $error("complement code is not the inverse");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
endmodule // dpmc_chk

bind dpmc_top dpmc_chk dpmc_chk_i (.*);

// ===== sim/dpmc_host_model.sv
// Host controller and board straps driving the shared control pins
`timescale 1ns/1ps
module dpmc_host_model
	import dpmc_pkg::*;
(
	// Clock
	input  wire logic                   core_clk_in,
	// Device side of the shared data line
	input  wire logic                   dev_data_in,
	input  wire logic                   dev_data_oe_in,
	// Pins toward the device
	output logic                        strap_mode_select_out,
	output logic                        retime_phase_pin_out,
	output logic                        format_pin_out,
	output logic                        powerdown_pin_out,
	output logic                        data_qualify_clock_out,
	output logic [DPMC_DATA_W-1:0]      sample_data_out
);
	logic host_fmt_r;
	logic host_oe_r;
	// Board pull-down wins only when nobody drives the line
	assign format_pin_out = dev_data_oe_in ? dev_data_in : (host_oe_r ? host_fmt_r : 1'b0);
	initial
	begin
		strap_mode_select_out = 1'b0;
		retime_phase_pin_out = 1'b0;
		host_fmt_r = 1'b0;
		host_oe_r = 1'b0;
		powerdown_pin_out = 1'b0;
		data_qualify_clock_out = 1'b0;
		sample_data_out = 14'h0000;
	end
	// Static levels; chip select low addresses the device
	task automatic set_pins(input logic s, input logic c, input logic f, input logic fo,
		input logic p);
		strap_mode_select_out <= s;
		retime_phase_pin_out <= c;
		host_fmt_r <= f;
		host_oe_r <= fo;
		powerdown_pin_out <= p;
	endtask
	// In-phase word on the data clock rise, quadrature on its fall
	task automatic send(input logic [DPMC_DATA_W-1:0] i_w, input logic [DPMC_DATA_W-1:0] q_w);
		@(posedge core_clk_in) sample_data_out <= i_w;
		@(posedge core_clk_in) data_qualify_clock_out <= 1'b1;
		@(posedge core_clk_in) sample_data_out <= q_w;
		@(posedge core_clk_in) data_qualify_clock_out <= 1'b0;
		@(posedge core_clk_in) sample_data_out <= ~q_w; // Stale bus after hold time
	endtask
	// Single low-to-high step to align the retimer
	task automatic align_step();
		@(posedge core_clk_in) retime_phase_pin_out <= 1'b0;
		@(posedge core_clk_in) retime_phase_pin_out <= 1'b1;
	endtask
endmodule // dpmc_host_model

// ===== sim/testbench.sv
// Self-checking bench for the control pin decoder
`timescale 1ns/1ps
module testbench;
	import dpmc_pkg::*;
	// Clock, reset and pins
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic strap_mode_select_in, retime_phase_pin_in, format_pin_in, powerdown_pin_in;
	logic data_qualify_clock_in, serial_data_drive_in, serial_data_oe_in;
	logic [DPMC_DATA_W-1:0] sample_data_in;
	// Device outputs
	logic format_pin_out, format_pin_oe_out, serial_clk_out, serial_cs_n_out, serial_data_out;
	logic serial_regs_reset_out, core_powerdown_out, retime_phase_out, retime_align_out;
	logic inphase_aux_output_en_out, quad_aux_output_en_out, reference_pin_drive_out;
	logic [DPMC_DATA_W-1:0] inphase_true_code_out, inphase_complement_code_out;
	logic [DPMC_DATA_W-1:0] quad_true_code_out, quad_complement_code_out;
	// Register bus
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [DPMC_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [DPMC_BUS_W-1:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [1:0]             s_axi_bresp, s_axi_rresp, rs;
	logic [2:0]             s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]             s_axi_wstrb = 4'hf;
	int fail_count = 0;
	int checks_done = 0;

	always #2 core_clk_in = ~core_clk_in;

	dpmc_top dpmc_top_i (.core_clk_in, .rst_in, .strap_mode_select_in, .retime_phase_pin_in,
		.format_pin_in, .format_pin_out, .format_pin_oe_out, .powerdown_pin_in, .serial_clk_out,
		.serial_cs_n_out, .serial_data_out, .serial_data_drive_in, .serial_data_oe_in,
		.serial_regs_reset_out, .data_qualify_clock_in, .sample_data_in, .inphase_true_code_out,
		.inphase_complement_code_out, .quad_true_code_out, .quad_complement_code_out,
		.core_powerdown_out, .retime_phase_out, .retime_align_out, .inphase_aux_output_en_out,
		.quad_aux_output_en_out, .reference_pin_drive_out, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

	dpmc_host_model dpmc_host_model_i (.core_clk_in, .dev_data_in(format_pin_out),
		.dev_data_oe_in(format_pin_oe_out), .strap_mode_select_out(strap_mode_select_in),
		.retime_phase_pin_out(retime_phase_pin_in), .format_pin_out(format_pin_in),
		.powerdown_pin_out(powerdown_pin_in), .data_qualify_clock_out(data_qualify_clock_in),
		.sample_data_out(sample_data_in));

	// Verdict and end of run
	task automatic final_report();
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Case-equal compare, so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask
	// Let a few edges land, then look between edges
	task automatic settle(input int k);
		repeat (k) @(posedge core_clk_in);
		#1;
	endtask
	// One bus transfer; handshakes sampled mid-cycle so no edge race
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw, w, ar, done;
		@(posedge core_clk_in);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 64; n++)
		begin
			@(negedge core_clk_in);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			ar = s_axi_arvalid & s_axi_arready;
			done = wr ? s_axi_bvalid : s_axi_rvalid;
			rs = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge core_clk_in);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (done === 1'b1)
			begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		fail_count++;
		final_report();
	endtask
	// Reset held four cycles with the strap at the given level
	task automatic restart(input logic strap);
		rst_in <= 1'b1;
		dpmc_host_model_i.set_pins(strap, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
	endtask

	// Strap high: formats, power-down freeze, retimer trigger
	task automatic pin_mode_run();
		int n;
		restart(1'b1);
		bus(1'b0, DPMC_OFF_STATUS, 32'h0);
		chk(rd[DPMC_STAT_PINMODE_BIT], 1'b1);
		dpmc_host_model_i.send(14'h1234, 14'h0abc);
		settle(4);
		chk(inphase_true_code_out, 14'h1234);
		chk(inphase_complement_code_out, 14'h2dcb);
		chk(quad_true_code_out, 14'h0abc);
		dpmc_host_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		dpmc_host_model_i.send(14'h1234, 14'h0000);
		settle(4);
		chk(inphase_true_code_out, 14'h3234);
		chk(quad_complement_code_out, 14'h1fff);
		dpmc_host_model_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		settle(3);
		chk(core_powerdown_out, 1'b1);
		dpmc_host_model_i.send(14'h0001, 14'h0002);
		settle(4);
		chk(inphase_true_code_out, 14'h3234);
		bus(1'b0, DPMC_OFF_STATUS, 32'h0);
		chk(rd[DPMC_STAT_PDOWN_BIT], 1'b1);
		chk(retime_phase_out, 1'b0);
		dpmc_host_model_i.align_step();
		n = 0;
		repeat (6)
		begin
			settle(1);
			if (retime_align_out === 1'b1) n++;
		end
		chk(n, 1);
		chk(retime_phase_out, 1'b1);
	endtask

	// Strap low: pin reuse, register access, strap-pulse reset
	task automatic serial_run();
		int i;
		@(posedge core_clk_in);
		restart(1'b0);
		dpmc_host_model_i.set_pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		settle(3);
		chk({serial_clk_out, serial_cs_n_out, serial_data_out}, 3'b101);
		dpmc_host_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		serial_data_drive_in <= 1'b1;
		serial_data_oe_in <= 1'b1;
		settle(3);
		chk({format_pin_oe_out, format_pin_out, serial_data_out}, 3'b111);
		dpmc_host_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		settle(3);
		chk({format_pin_oe_out, serial_cs_n_out}, 2'b01);
		serial_data_oe_in <= 1'b0;
		dpmc_host_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		bus(1'b1, DPMC_OFF_CTRL, 32'h1d);
		chk(rs, DPMC_RESP_OKAY);
		bus(1'b0, DPMC_OFF_CTRL, 32'h0);
		chk(rd, 32'h1d);
		chk({inphase_aux_output_en_out, quad_aux_output_en_out, reference_pin_drive_out}, 3'h7);
		for (i = 0; i < 2; i++)
		begin
			bus(i[0], 8'h0c, 32'h1);
			chk(rs, DPMC_RESP_SLVERR);
		end
		bus(1'b1, DPMC_OFF_STATUS, 32'h1);
		chk(rs, DPMC_RESP_SLVERR);
		@(posedge core_clk_in);
		dpmc_host_model_i.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge core_clk_in);
		dpmc_host_model_i.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		#1;
		chk(serial_regs_reset_out, 1'b1);
		bus(1'b0, DPMC_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk({inphase_aux_output_en_out, reference_pin_drive_out}, 2'b00);
		bus(1'b0, DPMC_OFF_STATUS, 32'h0);
		chk(rd[DPMC_STAT_PINMODE_BIT], 1'b0);
	endtask

	initial
	begin
		serial_data_drive_in = 1'b0;
		serial_data_oe_in = 1'b0;
		pin_mode_run();
		serial_run();
		final_report();
	end
endmodule // testbench
